// >>> logic/router_pkg.sv
package router_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ctrl_offset   = 8'h00;
  localparam logic [7:0] status_offset = 8'h04;

  // Control register fields
  localparam int cfg_pos      = 0;
  localparam int eaves_pos    = 2;
  localparam int bypass_pos   = 3;
  localparam int monitor_pos  = 4;
  localparam int duplex_pos   = 6;
  localparam int autodisc_pos = 7;

  // Status register fields
  localparam int st_bypass_pos = 0;
  localparam int st_dtr_pos    = 1;
  localparam int st_cts_pos    = 2;
  localparam int st_dsr_pos    = 3;
  localparam int st_dcd_pos    = 4;
  localparam int st_level_pos  = 5;

  // ****************************************************************
  // Settings encodings and reset values
  // ****************************************************************
  localparam logic [1:0] cfg_remote   = 2'h0;
  localparam logic [1:0] cfg_local    = 2'h1;
  localparam logic [1:0] cfg_standby  = 2'h2;

  localparam logic [1:0] mon_off      = 2'h0;
  localparam logic [1:0] mon_parse    = 2'h1;
  localparam logic [1:0] mon_receive  = 2'h2;

  localparam logic [1:0] disc_off              = 2'h0;
  localparam logic [1:0] switched_line_hangup  = 2'h1;
  localparam logic [1:0] hangup_a              = 2'h2;

  localparam logic       duplex_full  = 1'b0;
  localparam logic       duplex_half  = 1'b1;
  localparam logic       bypass_reset = 1'b0;
  localparam logic       dtr_reset    = 1'b1;

  // ****************************************************************
  // Escape sequence characters
  // ****************************************************************
  localparam logic [7:0] char_esc           = 8'h1b;
  localparam logic [7:0] char_dot           = 8'h2e;
  localparam logic [7:0] plotter_on_seq_a   = 8'h28;
  localparam logic [7:0] plotter_on_seq_b   = 8'h59;
  localparam logic [7:0] plotter_off_seq_a  = 8'h29;
  localparam logic [7:0] plotter_off_seq_b  = 8'h5a;

  localparam int fifo_width = 8;
  localparam int fifo_depth = 16;

  typedef enum logic [2:0] {
    scan_state = 3'b001,
    esc_state  = 3'b010,
    dot_state  = 3'b100
  } scan_type;

  typedef enum logic [1:0] {
    src_comp = 2'h0,
    src_term = 2'h1,
    src_exec = 2'h2
  } source_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } beat_type;

endpackage

// >>> logic/serial_passthrough_router.sv
`timescale 1ns/1ps

// ****************************************************************
// Byte FIFO
// ****************************************************************
module byte_fifo #(
  parameter int width = 8,
  parameter int depth = 16
) (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // Fill side
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [width-1:0]           in_data,
  // Drain side
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [width-1:0]                out_data,
  // Fill level
  output logic [$clog2(depth+1)-1:0]      level
);
  localparam int aw = $clog2(depth);

  logic [width-1:0] mem [depth];
  logic [aw-1:0]    wr_ptr;
  logic [aw-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (level != depth[$clog2(depth+1)-1:0]);
  assign out_valid = (level != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule // byte_fifo

module serial_passthrough_router
  import router_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Computer port receive and transmit bytes
  input  wire logic        comp_rx_valid,
  input  wire logic [7:0]  comp_rx_data,
  output logic             comp_rx_ready,
  output logic             comp_tx_valid,
  output logic [7:0]       comp_tx_data,
  input  wire logic        comp_tx_ready,
  // Terminal port receive and transmit bytes
  input  wire logic        term_rx_valid,
  input  wire logic [7:0]  term_rx_data,
  output logic             term_rx_ready,
  output logic             term_tx_valid,
  output logic [7:0]       term_tx_data,
  input  wire logic        term_tx_ready,
  // Plotter input stream and executed instruction stream
  output logic             plot_valid,
  output logic [7:0]       plot_data,
  input  wire logic        plot_ready,
  input  wire logic        exec_valid,
  input  wire logic [7:0]  exec_data,
  output logic             exec_ready,
  // Modem lines
  input  wire logic        cts,
  input  wire logic        dsr,
  input  wire logic        dcd,
  output logic             dtr,
  // Settings memory
  input  wire logic        nv_duplex_half,
  input  wire logic [1:0]  nv_autodisc,
  output logic             nv_save,
  output logic             nv_save_duplex_half,
  output logic [1:0]       nv_save_autodisc
);

  // ****************************************************************
  // Settings registers
  // ****************************************************************
  logic [1:0]  cfg;
  logic        eaves;
  logic        bypass;
  logic [1:0]  monitor;
  logic        duplex;
  logic [1:0]  autodisc;
  logic        restored;
  logic        apb_setup;
  logic        ctrl_wr;
  logic        standby;
  logic [4:0]  fifo_level;
  beat_type    fifo_in;
  logic        fifo_in_ready;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;

  assign apb_setup = psel && !penable;
  assign ctrl_wr   = psel && penable && pwrite && (paddr == ctrl_offset);
  assign standby   = (cfg == cfg_standby);
  assign pready    = 1'b1;

  // Debug echo and the route never come from settings memory
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg     <= cfg_remote;
      eaves   <= 1'b0;
      monitor <= mon_off;
    end else if (ctrl_wr) begin
      cfg     <= pwdata[cfg_pos +: 2];
      eaves   <= pwdata[eaves_pos];
      monitor <= pwdata[monitor_pos +: 2];
    end
  end

  // Saved settings are restored on the first edge after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restored <= 1'b0;
      duplex   <= duplex_full;
      autodisc <= disc_off;
    end else if (!restored) begin
      restored <= 1'b1;
      duplex   <= nv_duplex_half;
      autodisc <= nv_autodisc;
    end else if (ctrl_wr) begin
      duplex   <= pwdata[duplex_pos];
      autodisc <= pwdata[autodisc_pos +: 2];
    end
  end

  // Only the saved settings go out to settings memory
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_save             <= 1'b0;
      nv_save_duplex_half <= duplex_full;
      nv_save_autodisc    <= disc_off;
    end else begin
      nv_save <= ctrl_wr && restored;
      if (ctrl_wr) begin
        nv_save_duplex_half <= pwdata[duplex_pos];
        nv_save_autodisc    <= pwdata[autodisc_pos +: 2];
      end
    end
  end

  // ****************************************************************
  // Modem line synchronisers
  // ****************************************************************
  logic [2:0] line_pin;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] line;
  logic       lines_ok;
  logic       lines_ok_q;

  assign line_pin = {dcd, dsr, cts};

  // A level counts only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : line_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
          line[g]  <= 1'b0;
        end else begin
          sync1[g] <= line_pin[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g]) begin
            line[g] <= sync3[g];
          end
        end
      end
    end
  endgenerate

  always_comb begin
    unique case (autodisc)
      switched_line_hangup: lines_ok = line[0] && line[1];
      hangup_a:             lines_ok = line[0] && line[1] && line[2];
      default:              lines_ok = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dtr        <= dtr_reset;
      lines_ok_q <= 1'b1;
    end else begin
      dtr        <= lines_ok;
      lines_ok_q <= lines_ok;
    end
  end

  // ****************************************************************
  // Routing and arbitration
  // ****************************************************************
  logic comp_plot;
  logic comp_need_term;
  logic comp_want_term;
  logic comp_take;
  logic term_echo;
  logic term_want_term;
  logic term_take;
  logic exec_echo;
  logic exec_take;
  logic term_free;
  logic comp_free;
  source_type term_src;

  assign term_free      = !term_tx_valid || term_tx_ready;
  assign comp_free      = !comp_tx_valid || comp_tx_ready;
  // Standby leaves pass-through traffic alone but feeds nothing inward
  assign comp_plot      = !bypass && !standby;
  assign comp_need_term = bypass || (comp_plot && monitor == mon_receive);
  assign comp_want_term = comp_rx_valid && comp_need_term;
  assign comp_rx_ready  = (!comp_need_term || term_free)
                          && (!comp_plot || fifo_in_ready);
  assign comp_take      = comp_rx_valid && comp_rx_ready;

  assign term_echo      = (duplex == duplex_full) && !standby;
  assign term_want_term = term_rx_valid && term_echo;
  assign term_rx_ready  = (!bypass || comp_free)
                          && (!term_echo || (term_free && !comp_want_term));
  assign term_take      = term_rx_valid && term_rx_ready;

  assign exec_echo  = (monitor == mon_parse) && !standby;
  assign exec_ready = !exec_echo
                      || (term_free && !comp_want_term && !term_want_term);
  assign exec_take  = exec_valid && exec_ready;

  assign fifo_in = '{valid: comp_take && comp_plot, data: comp_rx_data};

  // Terminal output: computer bytes first, then local echo, then executed echo
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_tx_valid <= 1'b0;
      term_tx_data  <= 8'h00;
      term_src      <= src_comp;
    end else if (term_free) begin
      term_tx_valid <= 1'b0;
      if (comp_take && comp_need_term) begin
        term_tx_valid <= 1'b1;
        term_tx_data  <= comp_rx_data;
        term_src      <= src_comp;
      end else if (term_take && term_echo) begin
        term_tx_valid <= 1'b1;
        term_tx_data  <= term_rx_data;
        term_src      <= src_term;
      end else if (exec_take && exec_echo) begin
        term_tx_valid <= 1'b1;
        term_tx_data  <= exec_data;
        term_src      <= src_exec;
      end
    end
  end

  // Terminal bytes reach the computer only while the route is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_tx_valid <= 1'b0;
      comp_tx_data  <= 8'h00;
    end else if (comp_free) begin
      comp_tx_valid <= term_take && bypass;
      if (term_take && bypass) begin
        comp_tx_data <= term_rx_data;
      end
    end
  end

  // Plotter input buffer; a full buffer stalls the computer port while the route is off and not in standby
  byte_fifo #(
    .width (fifo_width),
    .depth (fifo_depth)
  ) plot_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (fifo_in.valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in.data),
    .out_valid (plot_valid),
    .out_ready (plot_ready),
    .out_data  (plot_data),
    .level     (fifo_level)
  );

  // ****************************************************************
  // Escape scanner and route state
  // ****************************************************************
  scan_type scan;
  logic     plot_on;
  logic     plot_off;
  logic     scan_byte;

  // Scanning continues while bytes are being forwarded to the terminal, except in standby
  assign scan_byte = comp_take && !standby;
  assign plot_on   = scan_byte && scan == dot_state
                     && (comp_rx_data == plotter_on_seq_a || comp_rx_data == plotter_on_seq_b);
  assign plot_off  = scan_byte && scan == dot_state
                     && (comp_rx_data == plotter_off_seq_a || comp_rx_data == plotter_off_seq_b);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan <= scan_state;
    end else if (scan_byte) begin
      unique case (scan)
        scan_state: scan <= (comp_rx_data == char_esc) ? esc_state : scan_state;
        esc_state:  scan <= (comp_rx_data == char_dot) ? dot_state
                          : (comp_rx_data == char_esc) ? esc_state : scan_state;
        dot_state:  scan <= (comp_rx_data == char_esc) ? esc_state : scan_state;
      endcase
    end
  end

  // A modem hang-up outranks escapes; standalone outranks everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bypass <= bypass_reset;
    end else if (ctrl_wr) begin
      if (!pwdata[eaves_pos]) begin
        bypass <= 1'b0;
      end else if (!eaves) begin
        bypass <= 1'b1;
      end else begin
        bypass <= pwdata[bypass_pos];
      end
    end else if (!eaves) begin
      bypass <= 1'b0;
    end else if (!lines_ok) begin
      bypass <= 1'b1;
    end else if (!lines_ok_q) begin
      bypass <= 1'b0;
    end else if (plot_on) begin
      bypass <= 1'b0;
    end else if (plot_off) begin
      bypass <= 1'b1;
    end
  end

  // ****************************************************************
  // APB read side
  // ****************************************************************
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[cfg_pos +: 2]      = cfg;
    ctrl_word[eaves_pos]         = eaves;
    ctrl_word[bypass_pos]        = bypass;
    ctrl_word[monitor_pos +: 2]  = monitor;
    ctrl_word[duplex_pos]        = duplex;
    ctrl_word[autodisc_pos +: 2] = autodisc;
    status_word = 32'h0000_0000;
    status_word[st_bypass_pos]     = bypass;
    status_word[st_dtr_pos]        = dtr;
    status_word[st_cts_pos]        = line[0];
    status_word[st_dsr_pos]        = line[1];
    status_word[st_dcd_pos]        = line[2];
    status_word[st_level_pos +: 5] = fifo_level;
  end

  // Read data is captured in the setup cycle, so reads take no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= !(paddr == ctrl_offset || (paddr == status_offset && !pwrite));
      if (pwrite) begin
        prdata <= 32'h0000_0000;
      end else if (paddr == ctrl_offset) begin
        prdata <= ctrl_word;
      end else if (paddr == status_offset) begin
        prdata <= status_word;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence esc_dot_seq;
    scan == esc_state && scan_byte && comp_rx_data == char_dot;
  endsequence

  chk_escape_scan: assert property (
    @(posedge pclk) disable iff (!presetn) esc_dot_seq |=> scan == dot_state)
    else $error("escape prefix not tracked");

  chk_standalone_route_off: assert property (
    @(posedge pclk) disable iff (!presetn) !eaves |-> !bypass)
    else $error("route on while standalone");

  chk_listen_in_on: assert property (
    @(posedge pclk) disable iff (!presetn) $rose(eaves) |-> bypass)
    else $error("route not set on when listen-in selected");

  chk_plot_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    comp_take && !bypass && !standby |-> fifo_in.valid && fifo_in_ready)
    else $error("computer byte not sent to plotter");

  chk_plotter_on_seq: assert property (
    @(posedge pclk) disable iff (!presetn)
    plot_on && eaves && lines_ok && lines_ok_q && !ctrl_wr |=> !bypass)
    else $error("plotter-on escape did not clear route");

  chk_plotter_off_seq: assert property (
    @(posedge pclk) disable iff (!presetn)
    plot_off && eaves && lines_ok && lines_ok_q && !ctrl_wr |=> bypass)
    else $error("plotter-off escape did not set route");

  chk_half_no_echo: assert property (
    @(posedge pclk) disable iff (!presetn)
    duplex == duplex_half && term_free |=> !(term_tx_valid && term_src == src_term))
    else $error("terminal byte echoed in half echo");

  chk_hangup_drop: assert property (
    @(posedge pclk) disable iff (!presetn)
    eaves && autodisc != disc_off && !lines_ok && !ctrl_wr |=> bypass && !dtr)
    else $error("modem line drop did not hang up");

  chk_disc_off_dtr: assert property (
    @(posedge pclk) disable iff (!presetn)
    autodisc == disc_off && $stable(autodisc) |=> dtr)
    else $error("dtr low with auto disconnect off");

  chk_standby_drop: assert property (
    @(posedge pclk) disable iff (!presetn)
    standby && term_free |=> (!term_tx_valid || term_src == src_comp)
                             && fifo_level <= $past(fifo_level))
    else $error("data accepted in standby");

endmodule // serial_passthrough_router

// >>> tb/line_sink.sv
`timescale 1ns/1ps

// ****************************************************************
// Far-side byte sink with random stalls
// ****************************************************************
module line_sink (
  // Clock
  input  wire logic       pclk,
  // Byte stream from the router
  input  wire logic       valid,
  input  wire logic [7:0] data,
  output logic            ready,
  // Stall request from the bench
  input  wire logic       hold
);
  logic [7:0]  got[$];
  logic [15:0] lfsr = 16'hace1;

  // Stalls at random so back-pressure paths are exercised
  always @(posedge pclk) begin
    if (valid && ready)
      got.push_back(data);
    lfsr  <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    ready <= !hold && lfsr[0];
  end
endmodule // line_sink

// >>> tb/test_serial_passthrough_router.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end

module test_serial_passthrough_router;
  import router_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, comp_rx_data = 8'h00, term_rx_data = 8'h00, exec_data = 8'h00;
  logic [7:0]  plot_data, comp_tx_data, term_tx_data, d;
  logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'h0000ac0f;
  logic        comp_rx_valid = 1'b0, term_rx_valid = 1'b0, exec_valid = 1'b0, hold = 1'b0;
  logic        cts = 1'b0, dsr = 1'b0, dcd = 1'b0, nv_duplex_half = 1'b0;
  logic [1:0]  nv_autodisc = 2'h0, nv_save_autodisc;
  logic        pready, pslverr, comp_rx_ready, comp_tx_valid, comp_tx_ready, term_rx_ready;
  logic        term_tx_valid, term_tx_ready, plot_valid, plot_ready, exec_ready, dtr;
  logic        nv_save, nv_save_duplex_half;
  logic [7:0]  codes[4] = '{plotter_on_seq_a, plotter_off_seq_a, plotter_on_seq_b,
                            plotter_off_seq_b};
  logic [7:0]  q[$];
  int          n_fail = 0, n_compared = 0, n, n_saves = 0;

  always #12.5 pclk = ~pclk;
  always @(posedge pclk) n_saves += (nv_save === 1'b1);

  serial_passthrough_router serial_passthrough_router_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .comp_rx_valid, .comp_rx_data,
    .comp_rx_ready, .comp_tx_valid, .comp_tx_data, .comp_tx_ready, .term_rx_valid,
    .term_rx_data, .term_rx_ready, .term_tx_valid, .term_tx_data, .term_tx_ready, .plot_valid,
    .plot_data, .plot_ready, .exec_valid, .exec_data, .exec_ready, .cts, .dsr, .dcd, .dtr,
    .nv_duplex_half, .nv_autodisc, .nv_save, .nv_save_duplex_half, .nv_save_autodisc);
  line_sink line_sink_inst (.pclk, .valid(term_tx_valid), .data(term_tx_data),
    .ready(term_tx_ready), .hold(1'b0));
  line_sink line_sink_inst_c (.pclk, .valid(comp_tx_valid), .data(comp_tx_data),
    .ready(comp_tx_ready), .hold(1'b0));
  line_sink line_sink_inst_p (.pclk, .valid(plot_valid), .data(plot_data),
    .ready(plot_ready), .hold);

  // ****************************************************************
  // Expectations and random bytes
  // ****************************************************************
  // Bytes stay in 40..7f so no escape appears by chance
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return {2'b01, seed[5:0]};
  endfunction
  function automatic logic [31:0] ctrl(input logic [1:0] c, input logic l, b,
                                       input logic [1:0] m, input logic u, input logic [1:0] a);
    return {23'h0, a, u, m, b, l, c};
  endfunction
  function automatic logic route_after(input logic [7:0] c);
    return c == plotter_off_seq_a || c == plotter_off_seq_b;
  endfunction
  function automatic logic line_ok(input logic [1:0] m);
    return m == disc_off || (cts && dsr && (m == switched_line_hangup || dcd));
  endfunction

  // ****************************************************************
  // Bus and stream tasks
  // ****************************************************************
  task summarize();
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 99; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 99) begin n_fail++; summarize(); end
    @(posedge pclk);
  endtask
  task put(input int s, input logic [7:0] b);
    int k;
    if (s == 0) begin comp_rx_valid <= 1'b1; comp_rx_data <= b; end
    else if (s == 1) begin term_rx_valid <= 1'b1; term_rx_data <= b; end
    else begin exec_valid <= 1'b1; exec_data <= b; end
    for (k = 0; k < 99; k++) begin
      @(posedge pclk);
      if ((s == 0 ? comp_rx_ready : s == 1 ? term_rx_ready : exec_ready) === 1'b1) break;
    end
    comp_rx_valid <= 1'b0;
    term_rx_valid <= 1'b0;
    exec_valid <= 1'b0;
    if (k == 99) begin n_fail++; summarize(); end
    @(posedge pclk);
  endtask
  task drain();
    int k;
    for (k = 0; k < 99 && (term_tx_valid | plot_valid | comp_tx_valid) !== 1'b0; k++)
      @(posedge pclk);
    if (k == 99) begin n_fail++; summarize(); end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, status_offset, 32'h0);
    `CHK(r[1:0], 2'h2)
    apb(1'b0, ctrl_offset, 32'h0);
    `CHK(r[6:4], 3'h0)
    apb(1'b0, 8'h08, 32'h0);
    `CHK({pslverr, r}, 33'h100000000)
    d = rnd();
    put(0, d);
    drain();
    `CHK(line_sink_inst_p.got[$], d)
    apb(1'b1, ctrl_offset, ctrl(cfg_remote, 1'b1, 1'b0, mon_off, duplex_full, disc_off));
    apb(1'b0, status_offset, 32'h0);
    `CHK(r[0], 1'b1)
    foreach (codes[i]) begin
      d = rnd();
      put(0, d);
      put(0, char_esc);
      put(0, char_dot);
      put(0, codes[i]);
      drain();
      apb(1'b0, status_offset, 32'h0);
      `CHK(r[0], route_after(codes[i]))
      // Even codes start with the route on, odd ones with it off
      n = i[0] ? line_sink_inst_p.got.size() : line_sink_inst.got.size();
      `CHK(i[0] ? line_sink_inst_p.got[n - 4] : line_sink_inst.got[n - 4], d)
    end
    for (int u = 0; u < 2; u++) begin
      apb(1'b1, ctrl_offset, ctrl(cfg_remote, 1'b1, 1'b1, mon_off, u[0], disc_off));
      `CHK(nv_save_duplex_half, u[0])
      n = line_sink_inst.got.size();
      d = rnd();
      put(1, d);
      drain();
      `CHK(line_sink_inst.got.size() - n, 1 - u)
      `CHK(line_sink_inst_c.got[$], d)
    end
    for (logic [1:0] m = switched_line_hangup; m <= hangup_a; m++) begin
      apb(1'b1, ctrl_offset, ctrl(cfg_remote, 1'b1, 1'b1, mon_off, duplex_full, m));
      `CHK(nv_save_autodisc, m)
      for (int s = 0; s < 3; s++) begin
        cts <= 1'b1;
        dsr <= s != 2;
        dcd <= s == 0;
        repeat (8) @(posedge pclk);
        apb(1'b0, status_offset, 32'h0);
        `CHK(dtr, line_ok(m))
        `CHK(r[0], !line_ok(m))
      end
    end
    apb(1'b1, ctrl_offset, ctrl(cfg_remote, 1'b0, 1'b0, mon_receive, duplex_full, disc_off));
    repeat (8) @(posedge pclk);
    `CHK(dtr, 1'b1)
    apb(1'b0, status_offset, 32'h0);
    `CHK(r[0], 1'b0)
    d = rnd();
    put(0, d);
    drain();
    `CHK(line_sink_inst_p.got[$], d)
    `CHK(line_sink_inst.got[$], d)
    apb(1'b1, ctrl_offset, ctrl(cfg_remote, 1'b0, 1'b0, mon_parse, duplex_full, disc_off));
    d = rnd();
    put(2, d);
    drain();
    `CHK(line_sink_inst.got[$], d)
    apb(1'b1, ctrl_offset, ctrl(cfg_standby, 1'b0, 1'b0, mon_off, duplex_full, disc_off));
    n = line_sink_inst_p.got.size();
    put(0, rnd());
    drain();
    `CHK(line_sink_inst_p.got.size(), n)
    apb(1'b1, ctrl_offset, 32'h0);
    hold <= 1'b1;
    repeat (fifo_depth) begin
      q.push_back(rnd());
      put(0, q[$]);
    end
    comp_rx_valid <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK(comp_rx_ready, 1'b0)
    comp_rx_valid <= 1'b0;
    apb(1'b0, status_offset, 32'h0);
    `CHK(r[9:5], 5'h10)
    hold <= 1'b0;
    @(posedge pclk);
    drain();
    n = line_sink_inst_p.got.size() - fifo_depth;
    foreach (q[i]) `CHK(line_sink_inst_p.got[n + i], q[i])
    `CHK(n_saves, 9)
    // Second reset: saved settings come back, volatile ones do not
    nv_duplex_half <= 1'b1;
    nv_autodisc <= hangup_a;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, ctrl_offset, 32'h0);
    `CHK(r[8:3], {hangup_a, duplex_half, mon_off, bypass_reset})
    `CHK(dtr, 1'b0)
    summarize();
  end
endmodule // test_serial_passthrough_router
